//--- hw/esi_top.v
// Purpose: External memory, bus handover, interrupt and control interface.
// Assumes: clk_sys is the input clock; software issues cycles over AXI.
// Notes: Every cycle is one external access, except a command cycle of kind RTI or an unused kind; no cache, so fetches are seen.
`timescale 1ns/1ns
`default_nettype none
`include "esi_defines.vh"
module esi_top #(
	parameter AW = 14,
	parameter PW = 24,
	parameter DW = 16
) (
	// System
	input  wire          clk_sys,
	input  wire          arst_n,
	// AXI4-Lite slave
	input  wire [7:0]    s_axi_awaddr,
	input  wire          s_axi_awvalid,
	output reg           s_axi_awready,
	input  wire [31:0]   s_axi_wdata,
	input  wire [3:0]    s_axi_wstrb,
	input  wire          s_axi_wvalid,
	output reg           s_axi_wready,
	output reg  [1:0]    s_axi_bresp,
	output reg           s_axi_bvalid,
	input  wire          s_axi_bready,
	input  wire [7:0]    s_axi_araddr,
	input  wire          s_axi_arvalid,
	output reg           s_axi_arready,
	output reg  [31:0]   s_axi_rdata,
	output reg  [1:0]    s_axi_rresp,
	output reg           s_axi_rvalid,
	input  wire          s_axi_rready,
	// Program memory port
	output reg  [AW-1:0] prog_mem_addr,
	output reg           prog_mem_ctl_oe,
	output reg           prog_mem_select_n,
	output reg           prog_mem_read_n,
	output reg           prog_mem_write_n,
	output reg           prog_mem_data_access,
	output reg  [PW-1:0] prog_mem_data_out,
	output reg           prog_mem_data_oe,
	input  wire [PW-1:0] prog_mem_data_in,
	// Data memory port
	output reg  [AW-1:0] data_mem_addr,
	output reg           data_mem_ctl_oe,
	output reg           data_mem_select_n,
	output reg           data_mem_read_n,
	output reg           data_mem_write_n,
	output reg  [DW-1:0] data_mem_data_out,
	output reg           data_mem_data_oe,
	input  wire [DW-1:0] data_mem_data_in,
	input  wire          data_mem_acknowledge,
	// Processor control
	input  wire          bus_request_n,
	output reg           bus_grant_n,
	input  wire [3:0]    irq_n,
	input  wire          halt_n,
	output reg           trap,
	output reg           cycle_clock_out
);
	localparam XW = PW - DW;
	localparam PH_RUN   = 2'h0;
	localparam PH_HALT  = 2'h1;
	localparam PH_TRAP  = 2'h2;
	localparam PH_GRANT = 2'h3;

	// Pin synchronisers: stage one feeds stage two only
	reg [5:0] sync1;
	reg [5:0] sync2;
	reg [3:0] irq_prev;
	always @(posedge clk_sys or negedge arst_n) begin
		if (!arst_n) begin
			sync1    <= 6'h00;
			sync2    <= 6'h00;
			irq_prev <= 4'h0;
		end else begin
			sync1    <= {~bus_request_n, ~halt_n, ~irq_n};
			sync2    <= sync1;
			irq_prev <= sync2[3:0];
		end
	end
	// Stages hold active-high levels and reset to idle, so no false edge
	wire [3:0] irq_lvl = sync2[3:0];
	wire       br_s    = sync2[5];
	wire       halt_s  = sync2[4];

	// Acknowledge synchroniser, active high
	reg ack1;
	reg ack2;
	always @(posedge clk_sys or negedge arst_n) begin
		if (!arst_n) begin
			ack1 <= 1'b0;
			ack2 <= 1'b0;
		end else begin
			ack1 <= data_mem_acknowledge;
			ack2 <= ack1;
		end
	end

	// Software-visible registers and engine state
	reg [3:0]    mode_control_reg;
	reg [3:0]    interrupt_enable_mask;
	reg [4:0]    interrupt_config;
	reg [XW-1:0] prog_word_extension_reg;
	reg [AW-1:0] cmd_addr;
	reg [2:0]    cmd_kind;
	reg          cmd_pend;
	reg [PW-1:0] wr_word;
	reg [PW-1:0] rd_word;
	reg [AW-1:0] pc;
	reg [3:0]    in_service;
	reg [3:0]    edge_lat;
	reg [2:0]    st;
	reg [1:0]    phase;
	reg          wext;
	reg          acc_pm;
	reg          acc_dm;
	reg          acc_rd;
	reg          acc_wr;
	reg          acc_cap;
	reg          trap_armed;

	// Interrupt request per level, gated by mask and service state
	wire [3:0] req;
	genvar gi;
	generate
		for (gi = 0; gi < 4; gi = gi + 1) begin : g_irq
			wire pend = interrupt_config[gi] ? edge_lat[gi] :
				irq_lvl[gi];
			wire free = interrupt_config[`ESI_ICFG_NEST] ?
				((in_service >> gi) == 4'h0) :
				(in_service == 4'h0);
			assign req[gi] = pend & interrupt_enable_mask[gi] & free;
		end
	endgenerate
	// Level 3 wins
	wire [1:0] lvl = req[3] ? 2'h3 : req[2] ? 2'h2 :
		req[1] ? 2'h1 : 2'h0;
	wire [3:0] lvl_bit = 4'h1 << lvl;
	wire [3:0] hi_isr = in_service[3] ? 4'h8 : in_service[2] ? 4'h4 :
		in_service[1] ? 4'h2 : in_service[0] ? 4'h1 : 4'h0;

	// Timing helpers
	wire [2:0] sn  = st + 3'h1;
	wire       ext = (st == `ESI_ST_SAMPLE) ?
		(acc_dm & ~ack2) : wext;
	wire       bnd = (phase == PH_RUN) && (st == `ESI_ST_END) && !wext;

	// AXI write side
	reg        aw_ok;
	reg        w_ok;
	reg [7:0]  aw_a;
	reg [31:0] w_d;
	reg [3:0]  w_s;
	wire       wr_fire = aw_ok & w_ok & ~s_axi_bvalid;
	wire       wr_map  = aw_a < `ESI_OFF_LIMIT;

	// Register view, one word per slot, used for reads and merges
	wire [255:0] view = {
		{16'h0, in_service, 1'b0, phase, trap, cmd_pend, wext, 3'h0,
			st},
		{8'h0, rd_word},
		{8'h0, wr_word},
		{cmd_pend, 12'h0, cmd_kind, 2'h0, cmd_addr},
		{{(32-XW){1'b0}}, prog_word_extension_reg},
		{27'h0, interrupt_config},
		{28'h0, interrupt_enable_mask},
		{28'h0, mode_control_reg}
	};
	wire [31:0] old_w = view[{aw_a[4:2], 5'h0} +: 32];
	wire [31:0] wmask = {{8{w_s[3]}}, {8{w_s[2]}},
		{8{w_s[1]}}, {8{w_s[0]}}};
	wire [31:0] nw = (old_w & ~wmask) | (w_d & wmask);

	// Handshakes for the write channels
	always @(posedge clk_sys or negedge arst_n) begin
		if (!arst_n) begin
			aw_ok <= 1'b0;
			w_ok <= 1'b0;
			aw_a <= 8'h00;
			w_d <= 32'h0;
			w_s <= 4'h0;
			s_axi_awready <= 1'b1;
			s_axi_wready <= 1'b1;
			s_axi_bvalid <= 1'b0;
			s_axi_bresp <= `ESI_RESP_OK;
		end else begin
			if (s_axi_awvalid && s_axi_awready) begin
				aw_ok <= 1'b1;
				aw_a <= s_axi_awaddr;
				s_axi_awready <= 1'b0;
			end
			if (s_axi_wvalid && s_axi_wready) begin
				w_ok <= 1'b1;
				w_d <= s_axi_wdata;
				w_s <= s_axi_wstrb;
				s_axi_wready <= 1'b0;
			end
			if (wr_fire) begin
				aw_ok <= 1'b0;
				w_ok <= 1'b0;
				s_axi_bvalid <= 1'b1;
				s_axi_bresp <= wr_map ? `ESI_RESP_OK : `ESI_RESP_ERR;
			end
			if (s_axi_bvalid && s_axi_bready) begin
				s_axi_bvalid <= 1'b0;
				s_axi_awready <= 1'b1;
				s_axi_wready <= 1'b1;
			end
		end
	end

	// Read channel: one cycle from address to data
	always @(posedge clk_sys or negedge arst_n) begin
		if (!arst_n) begin
			s_axi_arready <= 1'b1;
			s_axi_rvalid <= 1'b0;
			s_axi_rdata <= 32'h0;
			s_axi_rresp <= `ESI_RESP_OK;
		end else if (s_axi_arvalid && s_axi_arready) begin
			s_axi_arready <= 1'b0;
			s_axi_rvalid <= 1'b1;
			if (s_axi_araddr < `ESI_OFF_LIMIT) begin
				s_axi_rdata <= view[{s_axi_araddr[4:2], 5'h0} +: 32];
				s_axi_rresp <= `ESI_RESP_OK;
			end else begin
				s_axi_rdata <= 32'h0;
				s_axi_rresp <= `ESI_RESP_ERR;
			end
		end else if (s_axi_rvalid && s_axi_rready) begin
			s_axi_rvalid <= 1'b0;
			s_axi_arready <= 1'b1;
		end
	end

	// Cycle engine, pins and registers
	always @(posedge clk_sys or negedge arst_n) begin
		if (!arst_n) begin
			mode_control_reg <= 4'h0;
			interrupt_enable_mask <= 4'h0;
			interrupt_config <= 5'h00;
			prog_word_extension_reg <= {XW{1'b0}};
			cmd_addr <= {AW{1'b0}};
			cmd_kind <= 3'h0;
			cmd_pend <= 1'b0;
			wr_word <= {PW{1'b0}};
			rd_word <= {PW{1'b0}};
			pc <= `ESI_PC_RESET;
			in_service <= 4'h0;
			edge_lat <= 4'h0;
			st <= `ESI_ST_RESET;
			phase <= PH_RUN;
			wext <= 1'b0;
			acc_pm <= 1'b0;
			acc_dm <= 1'b0;
			acc_rd <= 1'b0;
			acc_wr <= 1'b0;
			acc_cap <= 1'b0;
			trap_armed <= 1'b0;
			prog_mem_addr <= `ESI_PC_RESET;
			prog_mem_ctl_oe <= 1'b1;
			prog_mem_select_n <= 1'b1;
			prog_mem_read_n <= 1'b1;
			prog_mem_write_n <= 1'b1;
			prog_mem_data_access <= 1'b0;
			prog_mem_data_out <= {PW{1'b0}};
			prog_mem_data_oe <= 1'b0;
			data_mem_addr <= {AW{1'b0}};
			data_mem_ctl_oe <= 1'b1;
			data_mem_select_n <= 1'b1;
			data_mem_read_n <= 1'b1;
			data_mem_write_n <= 1'b1;
			data_mem_data_out <= {DW{1'b0}};
			data_mem_data_oe <= 1'b0;
			bus_grant_n <= 1'b1;
			trap <= 1'b0;
			cycle_clock_out <= 1'b0;
		end else begin
			// Edge latch: a new edge wins over a clear in the same cycle
			edge_lat <= edge_lat | (irq_lvl & ~irq_prev);
			// Software writes; a command is refused while one is pending
			if (wr_fire && wr_map) begin
				case (aw_a)
				`ESI_OFF_MODE:   mode_control_reg <= nw[3:0];
				`ESI_OFF_INTERRUPT_ENABLE_MASK:  interrupt_enable_mask <= nw[3:0];
				`ESI_OFF_ICFG:   interrupt_config <= nw[4:0];
				`ESI_OFF_PX:     prog_word_extension_reg <= nw[XW-1:0];
				`ESI_OFF_WDATA:  wr_word <= nw[PW-1:0];
				`ESI_OFF_CMD: begin
					if (!cmd_pend) begin
						cmd_addr <= nw[AW-1:0];
						cmd_kind <= nw[`ESI_CMD_KIND_HI:`ESI_CMD_KIND_LO];
						cmd_pend <= 1'b1;
					end
				end
				default: ;
				endcase
			end
			case (phase)
			PH_RUN: begin
				st <= sn;
				// Clock out high in states 8,1,2,3
				cycle_clock_out <= (sn == `ESI_ST_END) ||
					(sn < `ESI_ST_CKLOW);
				if (st == `ESI_ST_SAMPLE) begin
					wext <= ext;
					if (!ext && acc_cap) begin
						if (acc_pm) begin
							rd_word <= prog_mem_data_in;
							prog_word_extension_reg <=
								prog_mem_data_in[XW-1:0];
						end else begin
							rd_word <= {{XW{1'b0}}, data_mem_data_in};
						end
					end
				end
				if (bnd) begin
					acc_pm <= 1'b0;
					acc_dm <= 1'b0;
					acc_rd <= 1'b0;
					acc_wr <= 1'b0;
					acc_cap <= 1'b0;
					prog_mem_data_oe <= 1'b0;
					data_mem_data_oe <= 1'b0;
					if (trap_armed) begin
						st <= st;
						trap <= 1'b1;
						trap_armed <= 1'b0;
						phase <= PH_TRAP;
						prog_mem_addr <= pc;
					end else if (br_s) begin
						st <= st;
						phase <= PH_GRANT;
						prog_mem_ctl_oe <= 1'b0;
						data_mem_ctl_oe <= 1'b0;
						bus_grant_n <= 1'b0;
					end else if (halt_s) begin
						st <= st;
						phase <= PH_HALT;
						prog_mem_addr <= pc;
					end else if (|req) begin
						// Vector fetch
						in_service <= in_service | lvl_bit;
						edge_lat <= (edge_lat & ~lvl_bit) |
							(irq_lvl & ~irq_prev);
						prog_mem_addr <= {{(AW-2){1'b0}}, lvl};
						pc <= {{(AW-2){1'b0}}, lvl} + 1'b1;
						prog_mem_select_n <= 1'b0;
						prog_mem_data_access <= 1'b0;
						acc_pm <= 1'b1;
						acc_rd <= 1'b1;
					end else if (cmd_pend) begin
						cmd_pend <= 1'b0;
						case (cmd_kind)
						`ESI_K_PROG_MEM_READ_N, `ESI_K_PROG_MEM_WRITE_N: begin
							prog_mem_addr <= cmd_addr;
							prog_mem_select_n <= 1'b0;
							prog_mem_data_access <= 1'b1;
							prog_mem_data_out <= {prog_word_extension_reg,
								wr_word[DW-1:0]};
							prog_mem_data_oe <= cmd_kind == `ESI_K_PROG_MEM_WRITE_N;
							acc_pm <= 1'b1;
							acc_rd <= cmd_kind == `ESI_K_PROG_MEM_READ_N;
							acc_wr <= cmd_kind == `ESI_K_PROG_MEM_WRITE_N;
							acc_cap <= cmd_kind == `ESI_K_PROG_MEM_READ_N;
						end
						`ESI_K_DATA_MEM_READ_N, `ESI_K_DATA_MEM_WRITE_N: begin
							data_mem_addr <= cmd_addr;
							data_mem_select_n <= 1'b0;
							data_mem_data_out <= wr_word[DW-1:0];
							data_mem_data_oe <= cmd_kind == `ESI_K_DATA_MEM_WRITE_N;
							acc_dm <= 1'b1;
							acc_rd <= cmd_kind == `ESI_K_DATA_MEM_READ_N;
							acc_wr <= cmd_kind == `ESI_K_DATA_MEM_WRITE_N;
							acc_cap <= cmd_kind == `ESI_K_DATA_MEM_READ_N;
						end
						`ESI_K_TRAP: begin
							prog_mem_addr <= pc;
							pc <= pc + 1'b1;
							prog_mem_select_n <= 1'b0;
							prog_mem_data_access <= 1'b0;
							acc_pm <= 1'b1;
							acc_rd <= 1'b1;
							trap_armed <= 1'b1;
						end
						`ESI_K_RTI: in_service <= in_service & ~hi_isr;
						default: ;
						endcase
					end else begin
						// Plain instruction fetch
						prog_mem_addr <= pc;
						pc <= pc + 1'b1;
						prog_mem_select_n <= 1'b0;
						prog_mem_data_access <= 1'b0;
						acc_pm <= 1'b1;
						acc_rd <= 1'b1;
					end
				end else begin
					// Strobe windows; a wait keeps them active
					prog_mem_select_n <= !(acc_pm &&
						(ext || sn != `ESI_ST_END));
					prog_mem_read_n <= !(acc_pm && acc_rd &&
						(ext || (sn >= `ESI_RD_FIRST &&
						sn != `ESI_ST_END)));
					prog_mem_write_n <= !(acc_pm && acc_wr &&
						sn >= `ESI_WR_FIRST && sn <= `ESI_WR_LAST);
					data_mem_select_n <= !(acc_dm &&
						(ext || sn != `ESI_ST_END));
					data_mem_read_n <= !(acc_dm && acc_rd &&
						(ext || (sn >= `ESI_RD_FIRST &&
						sn != `ESI_ST_END)));
					data_mem_write_n <= !(acc_dm && acc_wr &&
						(ext || (sn >= `ESI_WR_FIRST &&
						sn <= `ESI_WR_LAST)));
					if (sn == `ESI_ST_END && !ext)
						prog_mem_data_access <= 1'b0;
				end
			end
			PH_HALT: begin
				// Frozen at state 8
				if (!halt_s)
					phase <= PH_RUN;
			end
			PH_TRAP: begin
				if (halt_s) begin
					trap <= 1'b0;
					phase <= PH_HALT;
				end
			end
			PH_GRANT: begin
				if (!br_s) begin
					phase <= PH_RUN;
					prog_mem_ctl_oe <= 1'b1;
					data_mem_ctl_oe <= 1'b1;
					bus_grant_n <= 1'b1;
				end
			end
			default: phase <= PH_RUN;
			endcase
		end
	end
endmodule // esi_top
`default_nettype wire

//--- hw/esi_defines.vh
// Purpose: Shared constants of the external system interface.
// Assumes: One clk_sys edge per cycle state, eight states per cycle.
// Notes: AXI4-Lite offsets are byte addresses.
// What this block does
// - On bus request, finish the cycle, then float memory outputs and grant in the same state.
// - On request release, drive outputs again, drop grant, resume execution.
// - Program port has 14-bit address and 24-bit two-way data.
// - Program data-access output marks data cycles, timed like select.
// - Program select, write strobe and read strobe, all active low.
// - Program writes carry 24 bits, upper bits from extension register.
// - Data port has 14-bit address and 16-bit two-way data.
// - Data select, write strobe and read strobe, all active low.
// - Peripherals use data memory cycles, strobes and timing.
// - Acknowledge sampled in state 7 of each data memory cycle; missing acknowledge adds whole cycles.
// - Four active-low interrupts, maskable, level or edge, 3 highest.
// - Taken interrupt jumps to vector 0000 to 0003 by level.
// - Nesting lets higher levels preempt; otherwise none during service.
// - Reset clears timing, masks, mode; program address shows 0004.
// - Halt stops at instruction end with external fetch address visible.
// - Halted outputs stay static in state 8 until halt released.
// - Trap asserts trap output, stops in state 8, next address shown.
// - Trap stays until halt seen; stays stopped until halt released.
// - Reset release starts state 5 on a fixed clock edge.
// - Eight states per cycle; clock out high in states 8,1,2,3.
// - Sensitivity bit 0 selects level, 1 selects edge.
// - Service entry masks all, or with nesting equal and lower only.
`ifndef ESI_DEFINES_VH
`define ESI_DEFINES_VH
// Register byte offsets
`define ESI_OFF_MODE   8'h00
`define ESI_OFF_INTERRUPT_ENABLE_MASK  8'h04
`define ESI_OFF_ICFG   8'h08
`define ESI_OFF_PX     8'h0C
`define ESI_OFF_CMD    8'h10
`define ESI_OFF_WDATA  8'h14
`define ESI_OFF_RDATA  8'h18
`define ESI_OFF_STATUS 8'h1C
`define ESI_OFF_LIMIT  8'h20
// Command fields
`define ESI_CMD_KIND_HI 18
`define ESI_CMD_KIND_LO 16
`define ESI_ICFG_NEST   4
// Command kinds
`define ESI_K_PROG_MEM_READ_N 3'h1
`define ESI_K_PROG_MEM_WRITE_N 3'h2
`define ESI_K_DATA_MEM_READ_N 3'h3
`define ESI_K_DATA_MEM_WRITE_N 3'h4
`define ESI_K_TRAP 3'h5
`define ESI_K_RTI  3'h6
// State indices: index n is state n+1
`define ESI_ST_RESET  3'h4
`define ESI_ST_SAMPLE 3'h6
`define ESI_ST_END    3'h7
`define ESI_ST_CKLOW  3'h3
`define ESI_RD_FIRST  3'h1
`define ESI_WR_FIRST  3'h3
`define ESI_WR_LAST   3'h5
// Reset values and response codes
`define ESI_PC_RESET  14'h0004
`define ESI_RESP_OK   2'h0
`define ESI_RESP_ERR  2'h2
`endif

//--- tb/esi_top_asserts.sv
// Purpose: Port checks for the external system interface.
// Assumes: One clock domain; asynchronous active-low reset.
// Notes: Bound to every esi_top instance below.
`timescale 1ns/1ns
`default_nettype none
module esi_top_asserts (
	// System
	input wire logic        clk_sys,
	input wire logic        arst_n,
	// Program port
	input wire logic [13:0] prog_mem_addr,
	input wire logic        prog_mem_ctl_oe,
	input wire logic        prog_mem_select_n,
	input wire logic        prog_mem_read_n,
	input wire logic        prog_mem_write_n,
	input wire logic        prog_mem_data_oe,
	// Data port
	input wire logic        data_mem_ctl_oe,
	input wire logic        data_mem_select_n,
	input wire logic        data_mem_write_n,
	input wire logic        data_mem_data_oe,
	input wire logic        data_mem_acknowledge,
	// Control
	input wire logic        bus_request_n,
	input wire logic        bus_grant_n,
	input wire logic        trap,
	input wire logic        cycle_clock_out
);
	default clocking cb @(posedge clk_sys);
	endclocking
	default disable iff (!arst_n);

	// Granted and still requested: every driver stays off
	property p_float;
		!bus_grant_n && !bus_request_n |-> !(prog_mem_ctl_oe |
			data_mem_ctl_oe | prog_mem_data_oe | data_mem_data_oe);
	endproperty
	a_float: assert property (p_float)
		else $error("memory driver on while bus granted");

	// Release of the request gives the bus back within a few states
	property p_regain;
		$rose(bus_request_n) |-> ##[1:24] (bus_grant_n && prog_mem_ctl_oe);
	endproperty
	a_regain: assert property (p_regain)
		else $error("bus not returned after request release");

	// Program writes drive the whole word under select
	property p_pm_wr;
		!prog_mem_write_n |-> prog_mem_data_oe && !prog_mem_select_n;
	endproperty
	a_pm_wr: assert property (p_pm_wr)
		else $error("program write without select or data drive");

	// A read strobe never fights memory on the data lines
	property p_pm_rd;
		!prog_mem_read_n |-> !prog_mem_select_n && !prog_mem_data_oe
			&& prog_mem_write_n;
	endproperty
	a_pm_rd: assert property (p_pm_rd)
		else $error("program read strobe misused");

	property p_dm_wr;
		!data_mem_write_n |-> data_mem_data_oe && !data_mem_select_n;
	endproperty
	a_dm_wr: assert property (p_dm_wr)
		else $error("data write without select or data drive");

	// Missing acknowledge keeps the access open
	property p_ack;
		(!data_mem_select_n && !data_mem_acknowledge) [*4]
			|=> !data_mem_select_n;
	endproperty
	a_ack: assert property (p_ack)
		else $error("data access ended without acknowledge");

	// Low phase is states 4 to 7; freezes happen in state 8 only
	property p_clk;
		$fell(cycle_clock_out) |-> !cycle_clock_out [*4] ##1 cycle_clock_out;
	endproperty
	a_clk: assert property (p_clk)
		else $error("clock output low phase not four states");

	property p_trap;
		trap && $past(trap) |-> $stable(prog_mem_addr);
	endproperty
	a_trap: assert property (p_trap)
		else $error("program address moved while trapped");
endmodule // esi_top_asserts

bind esi_top esi_top_asserts i_chk (
	.clk_sys, .arst_n, .prog_mem_addr, .prog_mem_ctl_oe,
	.prog_mem_select_n, .prog_mem_read_n, .prog_mem_write_n,
	.prog_mem_data_oe, .data_mem_ctl_oe, .data_mem_select_n,
	.data_mem_write_n, .data_mem_data_oe, .data_mem_acknowledge,
	.bus_request_n, .bus_grant_n, .trap, .cycle_clock_out
);
`default_nettype wire

//--- tb/esi_mem_model.sv
// Purpose: Program and data memories on the far side of the block.
// Assumes: Strobes are sampled on clk_sys; acknowledge is active high.
// Notes: Released data lines toggle so stale captures show up.
`timescale 1ns/1ns
`default_nettype none
module esi_mem_model (
	// Clock
	input  wire logic        clk_sys,
	// Program port
	input  wire logic [13:0] prog_mem_addr,
	input  wire logic        prog_mem_select_n,
	input  wire logic        prog_mem_read_n,
	input  wire logic        prog_mem_write_n,
	input  wire logic        prog_mem_data_access,
	input  wire logic [23:0] prog_mem_data_out,
	output var  logic [23:0] prog_mem_data_in,
	// Data port
	input  wire logic [13:0] data_mem_addr,
	input  wire logic        data_mem_select_n,
	input  wire logic        data_mem_read_n,
	input  wire logic        data_mem_write_n,
	input  wire logic [15:0] data_mem_data_out,
	output var  logic [15:0] data_mem_data_in,
	output var  logic        data_mem_acknowledge,
	// States to wait before acknowledging
	input  wire logic [4:0]  ack_wait
);
	logic [23:0] pm [0:32767];
	logic [15:0] dm [0:16383];
	logic [23:0] pm_last = 24'h000000;
	logic [15:0] dm_last = 16'h0000;
	logic [4:0]  cnt = 5'h00;
	// Data-access line acts as a fifteenth address bit
	wire  [14:0] pm_idx = {prog_mem_data_access, prog_mem_addr};

	initial begin
		for (int i = 0; i < 32768; i++)
			pm[i] = 24'h000000;
		for (int i = 0; i < 16384; i++)
			dm[i] = 16'h0000;
	end

	// Writes land while select and strobe are low; wait count per access
	always @(posedge clk_sys) begin
		if (!prog_mem_select_n && !prog_mem_write_n)
			pm[pm_idx] <= prog_mem_data_out;
		if (!data_mem_select_n && !data_mem_write_n)
			dm[data_mem_addr] <= data_mem_data_out;
		pm_last <= prog_mem_data_in;
		dm_last <= data_mem_data_in;
		if (!data_mem_select_n && cnt != 5'h1F)
			cnt <= cnt + 5'h01;
		else if (data_mem_select_n && data_mem_acknowledge)
			cnt <= 5'h00;
	end

	// Slow peripheral: acknowledge only once the wait has run out
	always_comb begin
		prog_mem_data_in = (!prog_mem_select_n && !prog_mem_read_n) ?
			pm[pm_idx] : ~pm_last;
		data_mem_data_in = (!data_mem_select_n && !data_mem_read_n) ?
			dm[data_mem_addr] : ~dm_last;
		data_mem_acknowledge = (cnt >= ack_wait);
	end
endmodule // esi_mem_model
`default_nettype wire

//--- tb/esi_top_tb.sv
// Purpose: Self-checking bench for the external system interface.
// Assumes: AXI4-Lite master here; memories in esi_mem_model.
// Notes: Halt is exercised from the trapped state only.
`timescale 1ns/1ns
`default_nettype none
module esi_top_tb;
	typedef struct {
		logic [2:0] k; logic [13:0] a; logic [15:0] d;
		logic [7:0] px; logic [4:0] wt; logic [23:0] e;
	} esi_row_t;
	// Bench-driven inputs
	logic        clk_sys = 1'b0, arst_n = 1'b0;
	logic [7:0]  s_axi_awaddr = 8'h00, s_axi_araddr = 8'h00;
	logic [31:0] s_axi_wdata = 32'h00000000;
	logic [3:0]  s_axi_wstrb = 4'hF, irq_n = 4'hF;
	logic        s_axi_awvalid = 1'b0, s_axi_wvalid = 1'b0;
	logic        s_axi_bready = 1'b0, s_axi_arvalid = 1'b0;
	logic        s_axi_rready = 1'b0, bus_request_n = 1'b1, halt_n = 1'b1;
	logic [4:0]  ack_wait = 5'h00;
	// Design outputs and memory lines
	logic        s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready;
	logic        s_axi_rvalid, bus_grant_n, trap, cycle_clock_out;
	logic [1:0]  s_axi_bresp, s_axi_rresp;
	logic [31:0] s_axi_rdata;
	logic [13:0] prog_mem_addr, data_mem_addr;
	logic        prog_mem_ctl_oe, prog_mem_select_n, prog_mem_read_n;
	logic        prog_mem_write_n, prog_mem_data_access, prog_mem_data_oe;
	logic        data_mem_ctl_oe, data_mem_select_n, data_mem_read_n;
	logic        data_mem_write_n, data_mem_data_oe, data_mem_acknowledge;
	logic [23:0] prog_mem_data_out, prog_mem_data_in;
	logic [15:0] data_mem_data_out, data_mem_data_in;
	// Bookkeeping
	int          n_mismatch = 0, tests_run = 0;
	logic [31:0] rd;
	logic [1:0]  rsp;
	logic [13:0] pa, ha;
	logic        hit = 1'b0;
	esi_row_t    rows [6] = '{
		'{3'h2, 14'h3FFF, 16'hABCD, 8'h5A, 5'h00, 24'h5AABCD},
		'{3'h1, 14'h3FFF, 16'h0000, 8'h00, 5'h00, 24'h5AABCD},
		'{3'h4, 14'h0000, 16'h1234, 8'h00, 5'h00, 24'h001234},
		'{3'h3, 14'h0000, 16'h0000, 8'h00, 5'h00, 24'h001234},
		'{3'h4, 14'h2001, 16'hBEEF, 8'h00, 5'h0C, 24'h00BEEF},
		'{3'h3, 14'h2001, 16'h0000, 8'h00, 5'h0C, 24'h00BEEF}};

	esi_top i_dut (
		.clk_sys, .arst_n, .s_axi_awaddr, .s_axi_awvalid, .s_axi_awready,
		.s_axi_wdata, .s_axi_wstrb, .s_axi_wvalid, .s_axi_wready,
		.s_axi_bresp, .s_axi_bvalid, .s_axi_bready, .s_axi_araddr,
		.s_axi_arvalid, .s_axi_arready, .s_axi_rdata, .s_axi_rresp,
		.s_axi_rvalid, .s_axi_rready, .prog_mem_addr, .prog_mem_ctl_oe,
		.prog_mem_select_n, .prog_mem_read_n, .prog_mem_write_n,
		.prog_mem_data_access, .prog_mem_data_out, .prog_mem_data_oe,
		.prog_mem_data_in, .data_mem_addr, .data_mem_ctl_oe,
		.data_mem_select_n, .data_mem_read_n, .data_mem_write_n,
		.data_mem_data_out, .data_mem_data_oe, .data_mem_data_in,
		.data_mem_acknowledge, .bus_request_n, .bus_grant_n, .irq_n,
		.halt_n, .trap, .cycle_clock_out);

	esi_mem_model i_mem (
		.clk_sys, .prog_mem_addr, .prog_mem_select_n, .prog_mem_read_n,
		.prog_mem_write_n, .prog_mem_data_access, .prog_mem_data_out,
		.prog_mem_data_in, .data_mem_addr, .data_mem_select_n,
		.data_mem_read_n, .data_mem_write_n, .data_mem_data_out,
		.data_mem_data_in, .data_mem_acknowledge, .ack_wait);

	always #20 clk_sys = ~clk_sys;

	// First fetch inside the vector area; settled values at the low edge
	always @(negedge clk_sys)
		if (!hit && prog_mem_select_n === 1'b0 && prog_mem_addr < 14'h0004) begin
			hit <= 1'b1;
			pa <= prog_mem_addr;
		end

	task automatic chk(input string nm, input logic [31:0] e,
		input logic [31:0] g);
		tests_run++;
		if (g !== e) begin
			n_mismatch++;
			$display("[ERR] %s expected %h seen %h", nm, e, g);
		end
	endtask

	// Ready and valid are settled at the low edge, acted on at the next rise
	task automatic axw(input logic [7:0] a, input logic [31:0] d);
		logic ta, tw, tk;
		tk = 1'b0;
		@(posedge clk_sys);
		s_axi_awaddr <= a;
		s_axi_wdata <= d;
		s_axi_awvalid <= 1'b1;
		s_axi_wvalid <= 1'b1;
		s_axi_bready <= 1'b1;
		while (tk !== 1'b1) begin
			@(negedge clk_sys);
			ta = s_axi_awready;
			tw = s_axi_wready;
			tk = s_axi_bvalid;
			rsp = s_axi_bresp;
			@(posedge clk_sys);
			if (ta) s_axi_awvalid <= 1'b0;
			if (tw) s_axi_wvalid <= 1'b0;
		end
		s_axi_bready <= 1'b0;
	endtask

	task automatic axr(input logic [7:0] a);
		logic ta, tk;
		tk = 1'b0;
		@(posedge clk_sys);
		s_axi_araddr <= a;
		s_axi_arvalid <= 1'b1;
		s_axi_rready <= 1'b1;
		while (tk !== 1'b1) begin
			@(negedge clk_sys);
			ta = s_axi_arready;
			tk = s_axi_rvalid;
			rd = s_axi_rdata;
			rsp = s_axi_rresp;
			@(posedge clk_sys);
			if (ta) s_axi_arvalid <= 1'b0;
		end
		s_axi_rready <= 1'b0;
	endtask

	// Extension word, data word, command, then poll until not pending
	task automatic mem_op(input esi_row_t r);
		axw(8'h0C, {24'h000000, r.px});
		axw(8'h14, {16'h0000, r.d});
		axw(8'h10, {13'h0000, r.k, 2'h0, r.a});
		do
			axr(8'h1C);
		while (rd[7] === 1'b1);
		// Pending drops as the access starts; wait out the cycle and stretch
		repeat (9) @(negedge clk_sys);
		while (data_mem_select_n !== 1'b1) @(negedge clk_sys);
		@(posedge clk_sys);
	endtask

	task automatic do_reset;
		arst_n <= 1'b0;
		repeat (10) @(posedge clk_sys);
		chk("reset_addr", 32'h00000004, prog_mem_addr);
		arst_n <= 1'b1;
	endtask

	task automatic complete_run;
		$display("checks %0d mismatches %0d", tests_run, n_mismatch);
		if (n_mismatch == 0 && tests_run > 0)
			$display("verification passed");
		else
			$display("verification failed");
		$finish;
	endtask

	initial begin
		#(40 * 20000);
		n_mismatch++;
		complete_run;
	end

	initial begin
		do_reset;
		axr(8'h00);
		chk("mode", 32'h00000000, rd);
		axr(8'h04);
		chk("interrupt_enable_mask", 32'h00000000, rd);
		foreach (rows[i]) begin
			ack_wait <= rows[i].wt;
			mem_op(rows[i]);
			if (rows[i].k == 3'h2)
				chk("pm_word", rows[i].e, i_mem.pm[{1'b1, rows[i].a}]);
			else if (rows[i].k == 3'h4)
				chk("dm_word", rows[i].e, i_mem.dm[rows[i].a]);
			else begin
				axr(8'h18);
				chk("rdata", rows[i].e, rd);
			end
		end
		axr(8'h24);
		chk("rresp", 32'h00000002, rsp);
		axw(8'h28, 32'h00000000);
		chk("bresp", 32'h00000002, rsp);
		// Outside master takes the buses and keeps asking while it uses them
		bus_request_n <= 1'b0;
		while (bus_grant_n !== 1'b0) @(negedge clk_sys);
		chk("pm_ctl_oe", 32'h0, prog_mem_ctl_oe);
		chk("dm_ctl_oe", 32'h0, data_mem_ctl_oe);
		repeat (20) @(posedge clk_sys);
		bus_request_n <= 1'b1;
		while (bus_grant_n !== 1'b1) @(negedge clk_sys);
		chk("pm_ctl_oe_back", 32'h1, prog_mem_ctl_oe);
		mem_op(rows[3]);
		axr(8'h18);
		chk("resume", 32'h00001234, rd);
		// Levels 0 and 3 raised: masked first, then level 3 must win
		irq_n <= 4'b0110;
		repeat (64) @(negedge clk_sys);
		chk("masked", 32'h0, hit);
		axw(8'h04, 32'h0000000F);
		repeat (64) @(negedge clk_sys);
		chk("vector", 32'h00000003, pa);
		@(posedge clk_sys);
		irq_n <= 4'hF;
		do_reset;
		axw(8'h10, 32'h00050000);
		while (trap !== 1'b1) @(negedge clk_sys);
		repeat (24) @(posedge clk_sys);
		chk("trap_held", 32'h1, trap);
		do_reset;
		chk("trap_reset", 32'h0, trap);
		// Trap again, then halt clears it and holds; release resumes
		axw(8'h10, 32'h00050000);
		while (trap !== 1'b1) @(negedge clk_sys);
		@(posedge clk_sys);
		halt_n <= 1'b0;
		while (trap !== 1'b0) @(negedge clk_sys);
		ha = prog_mem_addr;
		repeat (24) @(negedge clk_sys);
		chk("halt_addr", {18'h0, ha}, prog_mem_addr);
		@(posedge clk_sys);
		halt_n <= 1'b1;
		while (prog_mem_addr === ha) @(negedge clk_sys);
		chk("halt_go", {18'h0, ha + 14'h1}, prog_mem_addr);
		complete_run;
	end
endmodule // esi_top_tb
`default_nettype wire
